// [radio_spi_regmap.sv]
// Functional notes
// - a non-burst-read access to 0x30..0x3D is a one-byte command strobe, not a transfer.
// - a burst read of 0x30..0x3D returns the read-only status registers.
// - 0x3E reaches the output power table; 0x3F writes the tx fifo and reads the rx fifo.
// - bit 6 of each pin config register selects active-low output, reset 0.
// - the pin-2 signal select resets to 0x29, the active-low chip-ready signal.
// - the pin-1 signal select resets to 0x2E, high impedance.
// - the pin-0 signal select resets to 0x3F, crystal clock divided by 192.
// - bit 7 of pin-1 config sets drive strength for all three pins, reset 0.
// - bit 7 of pin-0 config enables the temperature sensor, reset 0.
// - tx fifo threshold is 61 bytes at setting 0, four less per step, 1 at 15.
// - rx fifo threshold is 4 bytes at setting 0, four more per step; field resets to 7.
// - pin config and threshold registers keep their contents through sleep.
// - header byte is address plus 0x40 for burst and 0x80 for read.
// - the tx byte-count register reports tx fifo fill and underflow.
`timescale 1ns/1ps
module radio_spi_regmap #(
	parameter int POWER_TABLE_DEPTH = 8,
	parameter logic [7:0] PART_NUMBER_VALUE = 8'h5a, // arbitrary value
	parameter logic [7:0] CHIP_REVISION_VALUE = 8'h01 // arbitrary value
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	// spi pins from the host, sampled on CLK_IN
	input wire logic SCLK_IN,
	input wire logic CSN_IN,
	input wire logic MOSI_IN,
	output logic MISO_OUT,
	output logic MISO_OE_OUT,
	// command strobes
	output logic STROBE_VALID_OUT,
	output logic [5:0] STROBE_CODE_OUT,
	// tx fifo path
	output logic TX_VALID_OUT,
	output logic [7:0] TX_DATA_OUT,
	input wire logic TX_READY_IN,
	output logic TXBUF_FULL_OUT,
	// rx fifo path
	input wire logic RX_VALID_IN,
	input wire logic [7:0] RX_DATA_IN,
	output logic RX_READY_OUT,
	// status sources
	input wire logic [7:0] FREQ_EST_IN,
	input wire logic [7:0] LINK_QUALITY_IN,
	input wire logic [7:0] SIGNAL_STRENGTH_IN,
	input wire logic [4:0] RADIO_STATE_IN,
	input wire logic [15:0] WAKE_TIMER_IN,
	input wire logic [7:0] PACKET_STATUS_IN,
	input wire logic [7:0] SYNTH_CAL_IN,
	input wire logic [6:0] TX_COUNT_IN,
	input wire logic TX_UNDERFLOW_IN,
	input wire logic [6:0] RX_COUNT_IN,
	input wire logic RX_OVERFLOW_IN,
	input wire logic [6:0] RC_CAL_A_IN,
	input wire logic [6:0] RC_CAL_B_IN,
	// power table lookup
	input wire logic [2:0] POWER_INDEX_IN,
	output logic [7:0] POWER_LEVEL_OUT,
	// pin configuration
	output logic [5:0] PIN2_SIGNAL_SELECT_OUT,
	output logic PIN2_POLARITY_OUT,
	output logic [5:0] PIN1_SIGNAL_SELECT_OUT,
	output logic PIN1_POLARITY_OUT,
	output logic [5:0] PIN0_SIGNAL_SELECT_OUT,
	output logic PIN0_POLARITY_OUT,
	output logic PIN_DRIVE_STRENGTH_OUT,
	output logic TEMP_SENSOR_EN_OUT,
	// fifo thresholds
	output logic [3:0] QUEUE_THRESHOLD_SELECT_OUT,
	output logic TX_THRESH_OUT,
	output logic RX_THRESH_OUT
);
	function automatic logic in_strobe_range(input logic [5:0] a);
		in_strobe_range = (a >= radio_spi_pkg::STROBE_FIRST_ADDR) &&
			(a <= radio_spi_pkg::STROBE_LAST_ADDR);
	endfunction : in_strobe_range

	function automatic logic [6:0] threshold(input logic [6:0] base, input logic [3:0] sel,
			input logic rising);
		logic [6:0] span;
		span = 7'(radio_spi_pkg::THRESHOLD_STEP * {3'h0, sel});
		threshold = rising ? 7'(base + span) : 7'(base - span);
	endfunction : threshold

	// registers
	logic [7:0] pin2_cfg_q;
	logic [7:0] pin1_cfg_q;
	logic [7:0] pin0_cfg_q;
	logic [7:0] fifo_thr_q;
	logic [7:0] power_table_q [POWER_TABLE_DEPTH];
	// spi engine
	radio_spi_pkg::spi_phase_t phase_q;
	radio_spi_pkg::spi_phase_t phase_d;
	logic sclk_q;
	logic csn_q;
	logic [6:0] in_sh_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] out_sh_q;
	logic [7:0] out_sh_d;
	logic [5:0] addr_q;
	logic read_q;
	logic burst_q;
	logic [2:0] pa_idx_q;
	logic strobe_q;
	logic [5:0] strobe_code_q;
	logic tx_thr_q;
	logic rx_thr_q;

	wire sclk_rise = SCLK_IN & ~sclk_q & ~CSN_IN;
	wire sclk_fall = ~SCLK_IN & sclk_q & ~CSN_IN;
	wire cs_start = ~CSN_IN & csn_q;
	wire byte_done = sclk_rise & (bit_cnt_q == 3'd7);
	wire [7:0] rx_byte = {in_sh_q, MOSI_IN};
	wire hdr_done = byte_done & (phase_q == radio_spi_pkg::PH_HEADER);
	wire data_done = byte_done & (phase_q == radio_spi_pkg::PH_DATA);

	// header decode
	wire h_read = rx_byte[radio_spi_pkg::READ_BIT];
	wire h_burst = rx_byte[radio_spi_pkg::BURST_BIT];
	wire [5:0] h_addr = rx_byte[radio_spi_pkg::ADDR_MSB:0];
	wire is_strobe = hdr_done & in_strobe_range(h_addr) & ~(h_read & h_burst);
	wire soft_reset = is_strobe & (h_addr == radio_spi_pkg::SOFT_RESET_CMD);

	// address and index that the next byte will use
	wire cfg_space = addr_q < radio_spi_pkg::STROBE_FIRST_ADDR;
	wire pa_access = addr_q == radio_spi_pkg::OUTPUT_POWER_TABLE_ADDR;
	wire fifo_access = addr_q == radio_spi_pkg::FIFO_ACCESS_PORT_ADDR;
	wire [5:0] nxt_addr = hdr_done ? h_addr :
		(data_done & burst_q & cfg_space) ? 6'(addr_q + 6'h01) : addr_q;
	wire [2:0] nxt_pa_idx = hdr_done ? 3'h0 :
		(data_done & pa_access) ? 3'(pa_idx_q + 3'h1) : pa_idx_q;
	wire load_read = (hdr_done & ~is_strobe & h_read) | (data_done & burst_q & read_q);
	wire rx_pop = load_read & (nxt_addr == radio_spi_pkg::FIFO_ACCESS_PORT_ADDR);
	wire wr_data = data_done & ~read_q;

	// status byte shifted out during every header
	wire [6:0] tx_free = 7'(radio_spi_pkg::FIFO_DEPTH - TX_COUNT_IN);
	wire [3:0] free_sat = (tx_free > {3'h0, radio_spi_pkg::FREE_SATURATE}) ?
		radio_spi_pkg::FREE_SATURATE : tx_free[3:0];
	wire [7:0] chip_status = {1'b0, RADIO_STATE_IN[2:0], free_sat};

	// read multiplexer
	logic [7:0] rd_value;
	always_comb begin
		case (nxt_addr)
			radio_spi_pkg::PIN2_OUTPUT_CONFIG_ADDR: rd_value = pin2_cfg_q;
			radio_spi_pkg::PIN1_OUTPUT_CONFIG_ADDR: rd_value = pin1_cfg_q;
			radio_spi_pkg::PIN0_OUTPUT_CONFIG_ADDR: rd_value = pin0_cfg_q;
			radio_spi_pkg::FIFO_THRESHOLD_ADDR: rd_value = fifo_thr_q;
			radio_spi_pkg::PART_NUMBER_ADDR: rd_value = PART_NUMBER_VALUE;
			radio_spi_pkg::CHIP_REVISION_ADDR: rd_value = CHIP_REVISION_VALUE;
			radio_spi_pkg::FREQUENCY_OFFSET_ESTIMATE_ADDR: rd_value = FREQ_EST_IN;
			radio_spi_pkg::LINK_QUALITY_ADDR: rd_value = LINK_QUALITY_IN;
			radio_spi_pkg::SIGNAL_STRENGTH_ADDR: rd_value = SIGNAL_STRENGTH_IN;
			radio_spi_pkg::RADIO_STATE_ADDR: rd_value = {3'h0, RADIO_STATE_IN};
			radio_spi_pkg::WAKE_TIMER_HIGH_ADDR: rd_value = WAKE_TIMER_IN[15:8];
			radio_spi_pkg::WAKE_TIMER_LOW_ADDR: rd_value = WAKE_TIMER_IN[7:0];
			radio_spi_pkg::PACKET_PIN_STATUS_ADDR: rd_value = PACKET_STATUS_IN;
			radio_spi_pkg::SYNTH_CAL_SETTING_ADDR: rd_value = SYNTH_CAL_IN;
			radio_spi_pkg::TX_FILL_COUNT_ADDR: rd_value = {TX_UNDERFLOW_IN, TX_COUNT_IN};
			radio_spi_pkg::RX_FILL_COUNT_ADDR: rd_value = {RX_OVERFLOW_IN, RX_COUNT_IN};
			radio_spi_pkg::RC_CAL_RESULT_A_ADDR: rd_value = {1'b0, RC_CAL_A_IN};
			radio_spi_pkg::RC_CAL_RESULT_B_ADDR: rd_value = {1'b0, RC_CAL_B_IN};
			radio_spi_pkg::OUTPUT_POWER_TABLE_ADDR: rd_value = power_table_q[nxt_pa_idx];
			radio_spi_pkg::FIFO_ACCESS_PORT_ADDR: rd_value = RX_VALID_IN ? RX_DATA_IN : 8'h00;
			default: rd_value = 8'h00;
		endcase
	end

	// phase sequencing: single accesses fall back to a new header after one data byte
	always_comb begin
		case (phase_q)
			radio_spi_pkg::PH_IDLE: phase_d = cs_start ? radio_spi_pkg::PH_HEADER : phase_q;
			radio_spi_pkg::PH_HEADER: phase_d = (hdr_done & ~is_strobe) ?
				radio_spi_pkg::PH_DATA : phase_q;
			radio_spi_pkg::PH_DATA: phase_d = (data_done & ~burst_q) ?
				radio_spi_pkg::PH_HEADER : phase_q;
			default: phase_d = radio_spi_pkg::PH_IDLE;
		endcase
		if (CSN_IN)
			phase_d = radio_spi_pkg::PH_IDLE;
	end

	// next output byte: loaded at a byte boundary, shifted on falling sclk
	always_comb begin
		out_sh_d = out_sh_q;
		if (cs_start)
			out_sh_d = chip_status;
		else if (load_read)
			out_sh_d = rd_value;
		else if (byte_done)
			out_sh_d = chip_status;
		else if (sclk_fall && bit_cnt_q != 3'd0)
			out_sh_d = {out_sh_q[6:0], 1'b0};
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			phase_q <= radio_spi_pkg::PH_IDLE;
			sclk_q <= 1'b0;
			csn_q <= 1'b1;
			in_sh_q <= 7'h00;
			bit_cnt_q <= 3'h0;
			out_sh_q <= 8'h00;
		end else begin
			phase_q <= phase_d;
			sclk_q <= SCLK_IN;
			csn_q <= CSN_IN;
			out_sh_q <= out_sh_d;
			if (CSN_IN)
				bit_cnt_q <= 3'h0;
			else if (sclk_rise) begin
				in_sh_q <= rx_byte[6:0];
				bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			addr_q <= 6'h00;
			read_q <= 1'b0;
			burst_q <= 1'b0;
			pa_idx_q <= 3'h0;
			strobe_q <= 1'b0;
			strobe_code_q <= 6'h00;
		end else begin
			addr_q <= nxt_addr;
			pa_idx_q <= nxt_pa_idx;
			strobe_q <= is_strobe;
			if (is_strobe)
				strobe_code_q <= h_addr;
			if (hdr_done) begin
				read_q <= h_read;
				burst_q <= h_burst;
			end
		end
	end

	// configuration: only reset, the soft reset command and spi writes touch it, so sleep keeps it
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pin2_cfg_q <= radio_spi_pkg::PIN2_OUTPUT_CONFIG_RESET;
			pin1_cfg_q <= radio_spi_pkg::PIN1_OUTPUT_CONFIG_RESET;
			pin0_cfg_q <= radio_spi_pkg::PIN0_OUTPUT_CONFIG_RESET;
			fifo_thr_q <= radio_spi_pkg::FIFO_THRESHOLD_RESET;
		end else if (soft_reset) begin
			pin2_cfg_q <= radio_spi_pkg::PIN2_OUTPUT_CONFIG_RESET;
			pin1_cfg_q <= radio_spi_pkg::PIN1_OUTPUT_CONFIG_RESET;
			pin0_cfg_q <= radio_spi_pkg::PIN0_OUTPUT_CONFIG_RESET;
			fifo_thr_q <= radio_spi_pkg::FIFO_THRESHOLD_RESET;
		end else if (wr_data) begin
			// reserved bits are masked at write time so they always read as zero
			if (addr_q == radio_spi_pkg::PIN2_OUTPUT_CONFIG_ADDR)
				pin2_cfg_q <= rx_byte & radio_spi_pkg::PIN2_OUTPUT_CONFIG_MASK;
			if (addr_q == radio_spi_pkg::PIN1_OUTPUT_CONFIG_ADDR)
				pin1_cfg_q <= rx_byte;
			// is the host's duty; the bits are stored as written
			if (addr_q == radio_spi_pkg::PIN0_OUTPUT_CONFIG_ADDR)
				pin0_cfg_q <= rx_byte;
			if (addr_q == radio_spi_pkg::FIFO_THRESHOLD_ADDR)
				fifo_thr_q <= rx_byte & radio_spi_pkg::FIFO_THRESHOLD_MASK;
		end
	end

	// power table: burst steps the index, a new header restarts it at entry 0
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			for (int i = 0; i < POWER_TABLE_DEPTH; i++)
				power_table_q[i] <= radio_spi_pkg::OUTPUT_POWER_TABLE_RESET;
		end else if (wr_data && pa_access) begin
			power_table_q[pa_idx_q] <= rx_byte;
		end
	end

	// threshold compare against the fill counts reported by the fifos
	wire [3:0] thr_sel = fifo_thr_q[radio_spi_pkg::THRESHOLD_MSB:0];
	wire [6:0] tx_limit = threshold(radio_spi_pkg::TX_THRESHOLD_BASE, thr_sel, 1'b0);
	wire [6:0] rx_limit = threshold(radio_spi_pkg::RX_THRESHOLD_BASE, thr_sel, 1'b1);

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			tx_thr_q <= 1'b0;
			rx_thr_q <= 1'b0;
		end else begin
			tx_thr_q <= TX_COUNT_IN >= tx_limit;
			rx_thr_q <= RX_COUNT_IN >= rx_limit;
		end
	end

	// tx fifo bytes pass a two-entry buffer; a byte arriving while it is full is
	// dropped, since spi cannot be stalled, and TXBUF_FULL_OUT warns the host side
	wire buf_in_ready;
	byte_buffer2 #(
		.WIDTH(8)
	) tx_buffer (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.in_valid_in(wr_data & fifo_access),
		.in_data_in(rx_byte),
		.in_ready_out(buf_in_ready),
		.out_valid_out(TX_VALID_OUT),
		.out_data_out(TX_DATA_OUT),
		.out_ready_in(TX_READY_IN)
	);

	assign TXBUF_FULL_OUT = ~buf_in_ready;
	assign RX_READY_OUT = rx_pop & RX_VALID_IN;
	assign MISO_OUT = out_sh_q[7];
	assign MISO_OE_OUT = ~CSN_IN;
	assign STROBE_VALID_OUT = strobe_q;
	assign STROBE_CODE_OUT = strobe_code_q;
	assign POWER_LEVEL_OUT = power_table_q[POWER_INDEX_IN];
	assign PIN2_SIGNAL_SELECT_OUT = pin2_cfg_q[radio_spi_pkg::SELECT_MSB:0];
	assign PIN2_POLARITY_OUT = pin2_cfg_q[radio_spi_pkg::POLARITY_BIT];
	assign PIN1_SIGNAL_SELECT_OUT = pin1_cfg_q[radio_spi_pkg::SELECT_MSB:0];
	assign PIN1_POLARITY_OUT = pin1_cfg_q[radio_spi_pkg::POLARITY_BIT];
	assign PIN0_SIGNAL_SELECT_OUT = pin0_cfg_q[radio_spi_pkg::SELECT_MSB:0];
	assign PIN0_POLARITY_OUT = pin0_cfg_q[radio_spi_pkg::POLARITY_BIT];
	assign PIN_DRIVE_STRENGTH_OUT = pin1_cfg_q[radio_spi_pkg::DRIVE_STRENGTH_BIT];
	assign TEMP_SENSOR_EN_OUT = pin0_cfg_q[radio_spi_pkg::TEMP_SENSOR_BIT];
	assign QUEUE_THRESHOLD_SELECT_OUT = thr_sel;
	assign TX_THRESH_OUT = tx_thr_q;
	assign RX_THRESH_OUT = rx_thr_q;

endmodule : radio_spi_regmap

// [radio_spi_pkg.sv]
package radio_spi_pkg;

	// header byte layout
	localparam int READ_BIT = 7;
	localparam int BURST_BIT = 6;
	localparam int ADDR_MSB = 5;

	// register addresses
	localparam logic [5:0] PIN2_OUTPUT_CONFIG_ADDR = 6'h00;
	localparam logic [5:0] PIN1_OUTPUT_CONFIG_ADDR = 6'h01;
	localparam logic [5:0] PIN0_OUTPUT_CONFIG_ADDR = 6'h02;
	localparam logic [5:0] FIFO_THRESHOLD_ADDR = 6'h03;
	localparam logic [5:0] STROBE_FIRST_ADDR = 6'h30;
	localparam logic [5:0] STROBE_LAST_ADDR = 6'h3d;
	localparam logic [5:0] PART_NUMBER_ADDR = 6'h30;
	localparam logic [5:0] CHIP_REVISION_ADDR = 6'h31;
	localparam logic [5:0] FREQUENCY_OFFSET_ESTIMATE_ADDR = 6'h32;
	localparam logic [5:0] LINK_QUALITY_ADDR = 6'h33;
	localparam logic [5:0] SIGNAL_STRENGTH_ADDR = 6'h34;
	localparam logic [5:0] RADIO_STATE_ADDR = 6'h35;
	localparam logic [5:0] WAKE_TIMER_HIGH_ADDR = 6'h36;
	localparam logic [5:0] WAKE_TIMER_LOW_ADDR = 6'h37;
	localparam logic [5:0] PACKET_PIN_STATUS_ADDR = 6'h38;
	localparam logic [5:0] SYNTH_CAL_SETTING_ADDR = 6'h39;
	localparam logic [5:0] TX_FILL_COUNT_ADDR = 6'h3a;
	localparam logic [5:0] RX_FILL_COUNT_ADDR = 6'h3b;
	localparam logic [5:0] RC_CAL_RESULT_A_ADDR = 6'h3c;
	localparam logic [5:0] RC_CAL_RESULT_B_ADDR = 6'h3d;
	localparam logic [5:0] OUTPUT_POWER_TABLE_ADDR = 6'h3e;
	localparam logic [5:0] FIFO_ACCESS_PORT_ADDR = 6'h3f;

	// command strobe codes
	localparam logic [5:0] SOFT_RESET_CMD = 6'h30;
	localparam logic [5:0] SYNTH_ON_CMD = 6'h31;
	localparam logic [5:0] OSC_OFF_CMD = 6'h32;
	localparam logic [5:0] SYNTH_CALIBRATE_CMD = 6'h33;
	localparam logic [5:0] RECEIVE_CMD = 6'h34;
	localparam logic [5:0] TRANSMIT_CMD = 6'h35;
	localparam logic [5:0] GO_IDLE_CMD = 6'h36;
	localparam logic [5:0] WAKE_POLL_CMD = 6'h38;
	localparam logic [5:0] POWER_DOWN_CMD = 6'h39;
	localparam logic [5:0] FLUSH_RECEIVE_CMD = 6'h3a;
	localparam logic [5:0] FLUSH_TRANSMIT_CMD = 6'h3b;
	localparam logic [5:0] WAKE_TIMER_RESET_CMD = 6'h3c;
	localparam logic [5:0] NO_OPERATION_CMD = 6'h3d;

	// reset values and writable-bit masks
	localparam logic [7:0] PIN2_OUTPUT_CONFIG_RESET = 8'h29;
	localparam logic [7:0] PIN1_OUTPUT_CONFIG_RESET = 8'h2e;
	localparam logic [7:0] PIN0_OUTPUT_CONFIG_RESET = 8'h3f;
	localparam logic [7:0] FIFO_THRESHOLD_RESET = 8'h07;
	localparam logic [7:0] PIN2_OUTPUT_CONFIG_MASK = 8'h7f;
	localparam logic [7:0] FIFO_THRESHOLD_MASK = 8'h0f;
	localparam logic [7:0] OUTPUT_POWER_TABLE_RESET = 8'h00;

	// field positions
	localparam int DRIVE_STRENGTH_BIT = 7;
	localparam int TEMP_SENSOR_BIT = 7;
	localparam int POLARITY_BIT = 6;
	localparam int SELECT_MSB = 5;
	localparam int THRESHOLD_MSB = 3;

	// fifo thresholds: tx falls and rx rises by one step per setting
	localparam logic [6:0] TX_THRESHOLD_BASE = 7'h3d;
	localparam logic [6:0] RX_THRESHOLD_BASE = 7'h04;
	localparam logic [6:0] THRESHOLD_STEP = 7'h04;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [3:0] FREE_SATURATE = 4'hf;

	typedef enum logic [1:0] {PH_IDLE, PH_HEADER, PH_DATA} spi_phase_t;

endpackage : radio_spi_pkg

// [byte_buffer2.sv]
`timescale 1ns/1ps
module byte_buffer2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// filling side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// draining side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	logic [WIDTH-1:0] slot_q [2];
	logic [1:0] count_q;
	logic rd_ptr_q;
	logic wr_ptr_q;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;

	assign in_ready_out = (count_q != 2'd2);
	assign out_valid_out = (count_q != 2'd0);
	assign out_data_out = slot_q[rd_ptr_q];

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_q <= 2'd0;
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
			slot_q[0] <= '0;
			slot_q[1] <= '0;
		end else begin
			if (push) begin
				slot_q[wr_ptr_q] <= in_data_in;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule : byte_buffer2

// [radio_spi_regmap_props.sv]
`timescale 1ns/1ps
module radio_spi_regmap_props (
	// clock, reset, select
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic CSN_IN,
	input wire logic MISO_OE_OUT,
	// strobes and streams
	input wire logic STROBE_VALID_OUT,
	input wire logic [5:0] STROBE_CODE_OUT,
	input wire logic TX_VALID_OUT,
	input wire logic [7:0] TX_DATA_OUT,
	input wire logic TX_READY_IN,
	input wire logic TXBUF_FULL_OUT,
	input wire logic RX_VALID_IN,
	input wire logic RX_READY_OUT,
	// thresholds
	input wire logic [6:0] TX_COUNT_IN,
	input wire logic [6:0] RX_COUNT_IN,
	input wire logic [3:0] QUEUE_THRESHOLD_SELECT_OUT,
	input wire logic TX_THRESH_OUT,
	input wire logic RX_THRESH_OUT,
	// pin configuration
	input wire logic [5:0] PIN2_SIGNAL_SELECT_OUT,
	input wire logic [5:0] PIN1_SIGNAL_SELECT_OUT,
	input wire logic [5:0] PIN0_SIGNAL_SELECT_OUT,
	input wire logic PIN2_POLARITY_OUT,
	input wire logic PIN1_POLARITY_OUT,
	input wire logic PIN0_POLARITY_OUT,
	input wire logic PIN_DRIVE_STRENGTH_OUT,
	input wire logic TEMP_SENSOR_EN_OUT
);
	wire logic [6:0] tx_limit = 7'h3d - {1'b0, QUEUE_THRESHOLD_SELECT_OUT, 2'b00};
	wire logic [6:0] rx_limit = 7'h04 + {1'b0, QUEUE_THRESHOLD_SELECT_OUT, 2'b00};

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	sequence strobe_pulse;
		STROBE_VALID_OUT ##1 !STROBE_VALID_OUT;
	endsequence

	a_strobe_single: assert property ($rose(STROBE_VALID_OUT) |-> strobe_pulse)
		else $error("strobe pulse longer than one cycle");
	a_strobe_code: assert property (STROBE_VALID_OUT |-> STROBE_CODE_OUT >= 6'h30
		&& STROBE_CODE_OUT <= 6'h3d && !$past(CSN_IN)) else $error("strobe code or frame wrong");
	a_oe_select: assert property (MISO_OE_OUT == !CSN_IN)
		else $error("data out enable not tied to select");
	a_tx_thresh: assert property (1'b1 |=> TX_THRESH_OUT ==
		($past(TX_COUNT_IN) >= $past(tx_limit))) else $error("tx threshold flag wrong");
	a_rx_thresh: assert property (1'b1 |=> RX_THRESH_OUT ==
		($past(RX_COUNT_IN) >= $past(rx_limit))) else $error("rx threshold flag wrong");
	a_rx_take: assert property (RX_READY_OUT |-> RX_VALID_IN && !CSN_IN)
		else $error("rx byte taken without valid or frame");
	a_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=>
		TX_VALID_OUT && $stable(TX_DATA_OUT)) else $error("tx byte lost while stalled");
	a_full_valid: assert property (TXBUF_FULL_OUT |-> TX_VALID_OUT)
		else $error("full buffer shows no valid");
	a_tx_frame: assert property ($rose(TX_VALID_OUT) |-> !$past(CSN_IN))
		else $error("tx byte appeared outside a frame");
	a_reset_fields: assert property ($rose(ARST_N_IN) |-> PIN2_SIGNAL_SELECT_OUT == 6'h29
		&& PIN1_SIGNAL_SELECT_OUT == 6'h2e && PIN0_SIGNAL_SELECT_OUT == 6'h3f
		&& !PIN2_POLARITY_OUT && !PIN1_POLARITY_OUT && !PIN0_POLARITY_OUT
		&& !PIN_DRIVE_STRENGTH_OUT && !TEMP_SENSOR_EN_OUT
		&& QUEUE_THRESHOLD_SELECT_OUT == 4'h7) else $error("field reset value wrong");
endmodule : radio_spi_regmap_props

bind radio_spi_regmap radio_spi_regmap_props u_props (.CLK_IN, .ARST_N_IN, .CSN_IN,
	.MISO_OE_OUT, .STROBE_VALID_OUT, .STROBE_CODE_OUT, .TX_VALID_OUT, .TX_DATA_OUT,
	.TX_READY_IN, .TXBUF_FULL_OUT, .RX_VALID_IN, .RX_READY_OUT, .TX_COUNT_IN, .RX_COUNT_IN,
	.QUEUE_THRESHOLD_SELECT_OUT, .TX_THRESH_OUT, .RX_THRESH_OUT, .PIN2_SIGNAL_SELECT_OUT,
	.PIN1_SIGNAL_SELECT_OUT, .PIN0_SIGNAL_SELECT_OUT, .PIN2_POLARITY_OUT, .PIN1_POLARITY_OUT,
	.PIN0_POLARITY_OUT, .PIN_DRIVE_STRENGTH_OUT, .TEMP_SENSOR_EN_OUT);

// [spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
	// clock
	input wire logic clk_in,
	// spi pins
	output logic sclk_out,
	output logic csn_n_out,
	output logic mosi_out,
	input wire logic miso_in
);
	initial begin
		sclk_out = 1'b0;
		csn_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// unselected data line toggles so the device cannot lean on a stale bit
	always @(posedge clk_in) begin
		if (csn_n_out) begin
			mosi_out <= ~mosi_out;
		end
	end

	task automatic select();
		@(posedge clk_in);
		csn_n_out <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask : select

	// mode 0, msb first; sclk stays low for three system cycles and high for two
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_in);
			mosi_out <= tx[i];
			repeat (2) @(posedge clk_in);
			rx[i] = miso_in;
			sclk_out <= 1'b1;
			repeat (2) @(posedge clk_in);
			sclk_out <= 1'b0;
		end
	endtask : shift_byte

	task automatic deselect();
		repeat (2) @(posedge clk_in);
		csn_n_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : deselect
endmodule : spi_host_model

// [test_radio_spi_regmap.sv]
`timescale 1ns/1ps
module test_radio_spi_regmap;
	logic CLK_IN, ARST_N_IN, SCLK_IN, CSN_IN, MOSI_IN, MISO_OUT, MISO_OE_OUT;
	logic STROBE_VALID_OUT, TX_VALID_OUT, TX_READY_IN, TXBUF_FULL_OUT, RX_VALID_IN, RX_READY_OUT;
	logic [5:0] STROBE_CODE_OUT, PIN2_SIGNAL_SELECT_OUT, PIN1_SIGNAL_SELECT_OUT, PIN0_SIGNAL_SELECT_OUT;
	logic [7:0] TX_DATA_OUT, RX_DATA_IN, FREQ_EST_IN, LINK_QUALITY_IN, SIGNAL_STRENGTH_IN;
	logic [7:0] PACKET_STATUS_IN, SYNTH_CAL_IN, POWER_LEVEL_OUT;
	logic [4:0] RADIO_STATE_IN;
	logic [15:0] WAKE_TIMER_IN;
	logic [6:0] TX_COUNT_IN, RX_COUNT_IN, RC_CAL_A_IN, RC_CAL_B_IN;
	logic TX_UNDERFLOW_IN, RX_OVERFLOW_IN, PIN2_POLARITY_OUT, PIN1_POLARITY_OUT, PIN0_POLARITY_OUT;
	logic PIN_DRIVE_STRENGTH_OUT, TEMP_SENSOR_EN_OUT, TX_THRESH_OUT, RX_THRESH_OUT;
	logic [2:0] POWER_INDEX_IN;
	logic [3:0] QUEUE_THRESHOLD_SELECT_OUT;
	logic [5:0] strobe_last;
	logic [7:0] rd [4];
	int err_count, num_checks, strobe_hits, take_hits;
	localparam logic [7:0] PART_ID = 8'h6c; // arbitrary value
	localparam logic [7:0] REV_ID = 8'h03; // arbitrary value

	radio_spi_regmap #(.PART_NUMBER_VALUE(PART_ID), .CHIP_REVISION_VALUE(REV_ID)) u_dut (.*);
	spi_host_model u_host (.clk_in(CLK_IN), .sclk_out(SCLK_IN), .csn_n_out(CSN_IN),
		.mosi_out(MOSI_IN), .miso_in(MISO_OUT));

	initial begin
		CLK_IN = 1'b0;
		forever #25 CLK_IN = ~CLK_IN;
	end

	always @(posedge CLK_IN) begin
		if (STROBE_VALID_OUT === 1'b1) begin
			strobe_hits++;
			strobe_last = STROBE_CODE_OUT;
		end
		if (RX_READY_OUT === 1'b1) take_hits++;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task automatic xfer(input logic [7:0] hdr, input int n, input logic [7:0] wd [4]);
		logic [7:0] st;
		u_host.select();
		u_host.shift_byte(hdr, st);
		for (int i = 0; i < n; i++) u_host.shift_byte(wd[i], rd[i]);
		u_host.deselect();
	endtask : xfer

	// compares the pin and threshold fields at the ports and a burst read of the same four registers
	task automatic check_config(input logic [7:0] exp [4]);
		logic [7:0] got [4];
		got = '{{1'b0, PIN2_POLARITY_OUT, PIN2_SIGNAL_SELECT_OUT},
			{PIN_DRIVE_STRENGTH_OUT, PIN1_POLARITY_OUT, PIN1_SIGNAL_SELECT_OUT},
			{TEMP_SENSOR_EN_OUT, PIN0_POLARITY_OUT, PIN0_SIGNAL_SELECT_OUT},
			{4'h0, QUEUE_THRESHOLD_SELECT_OUT}};
		xfer(8'hc0, 4, '{default: 8'h00});
		for (int i = 0; i < 4; i++) begin
			chk("config field", exp[i], got[i]);
			chk("config readback", exp[i], rd[i]);
		end
	endtask : check_config

	task automatic s_status();
		logic [5:0] adr [14];
		logic [7:0] exp [14];
		adr = '{6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3a, 6'h3b,
			6'h35, 6'h3c, 6'h3d};
		exp = '{PART_ID, REV_ID, FREQ_EST_IN, LINK_QUALITY_IN, SIGNAL_STRENGTH_IN,
			WAKE_TIMER_IN[15:8], WAKE_TIMER_IN[7:0], PACKET_STATUS_IN, SYNTH_CAL_IN,
			{TX_UNDERFLOW_IN, TX_COUNT_IN}, {RX_OVERFLOW_IN, RX_COUNT_IN},
			{3'h0, RADIO_STATE_IN}, {1'b0, RC_CAL_A_IN}, {1'b0, RC_CAL_B_IN}};
		for (int i = 0; i < 14; i++) begin
			xfer({2'b11, adr[i]}, 2, '{default: 8'h00});
			chk("status byte", exp[i], rd[0]);
			chk("status repeat", exp[i], rd[1]);
		end
		chk("strobes on status read", 8'h00, 8'(strobe_hits));
	endtask : s_status

	task automatic s_strobes();
		logic [5:0] codes [13];
		int n0;
		codes = '{6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h38, 6'h39, 6'h3a, 6'h3b,
			6'h3c, 6'h3d};
		for (int i = 0; i < 13; i++) begin
			n0 = strobe_hits;
			// single write, single read and burst write all count as strobes
			xfer({(i % 3 == 1) ? 2'b10 : (i % 3 == 2) ? 2'b01 : 2'b00, codes[i]}, 0,
				'{default: 8'h00});
			chk("strobe count", 8'h01, 8'(strobe_hits - n0));
			chk("strobe code", {2'b00, codes[i]}, {2'b00, strobe_last});
		end
	endtask : s_strobes

	task automatic s_config();
		xfer(8'h40, 4, '{8'hff, 8'hc5, 8'h80, 8'hff});
		check_config('{8'h7f, 8'hc5, 8'h80, 8'h0f});
		xfer(8'h39, 0, '{default: 8'h00});
		xfer(8'h36, 0, '{default: 8'h00});
		check_config('{8'h7f, 8'hc5, 8'h80, 8'h0f});
		xfer(8'h02, 1, '{8'h45, 8'h00, 8'h00, 8'h00});
		xfer(8'h82, 1, '{default: 8'h00});
		chk("single readback", 8'h45, rd[0]);
		xfer(8'h10, 1, '{default: 8'hff});
		xfer(8'h90, 1, '{default: 8'h00});
		chk("unmapped read", 8'h00, rd[0]);
		xfer(8'h30, 0, '{default: 8'h00});
		chk("select after soft reset", 8'h29, {2'b00, PIN2_SIGNAL_SELECT_OUT});
	endtask : s_config

	task automatic s_thresholds();
		for (int s = 0; s < 16; s++) begin
			xfer(8'h03, 1, '{8'(s), 8'h00, 8'h00, 8'h00});
			TX_COUNT_IN <= 7'(61 - 4 * s);
			RX_COUNT_IN <= 7'(3 + 4 * s);
			repeat (3) @(posedge CLK_IN);
			chk("tx flag at limit", 8'h01, {7'h00, TX_THRESH_OUT});
			chk("rx flag below limit", 8'h00, {7'h00, RX_THRESH_OUT});
			TX_COUNT_IN <= 7'(60 - 4 * s);
			RX_COUNT_IN <= 7'(4 + 4 * s);
			repeat (3) @(posedge CLK_IN);
			chk("tx flag below limit", 8'h00, {7'h00, TX_THRESH_OUT});
			chk("rx flag at limit", 8'h01, {7'h00, RX_THRESH_OUT});
		end
	endtask : s_thresholds

	task automatic s_fifo();
		int got;
		int n0;
		got = 0;
		xfer(8'h7f, 3, '{8'h11, 8'h22, 8'h33, 8'h00});
		chk("buffer full", 8'h01, {7'h00, TXBUF_FULL_OUT});
		TX_READY_IN <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			@(posedge CLK_IN);
			if (TX_VALID_OUT === 1'b1) begin
				chk("tx byte", (got == 0) ? 8'h11 : 8'h22, TX_DATA_OUT);
				got++;
			end
		end
		chk("tx bytes kept", 8'h02, 8'(got));
		RX_VALID_IN <= 1'b1;
		RX_DATA_IN <= 8'ha7;
		n0 = take_hits;
		xfer(8'hbf, 1, '{default: 8'h00});
		chk("rx byte", 8'ha7, rd[0]);
		chk("rx takes", 8'h01, 8'(take_hits - n0));
		RX_VALID_IN <= 1'b0;
		xfer(8'h7e, 2, '{8'h3c, 8'hc3, 8'h00, 8'h00});
		POWER_INDEX_IN <= 3'h1;
		repeat (2) @(posedge CLK_IN);
		chk("power level", 8'hc3, POWER_LEVEL_OUT);
		xfer(8'hfe, 2, '{default: 8'h00});
		chk("power table 0", 8'h3c, rd[0]);
		chk("power table 1", 8'hc3, rd[1]);
	endtask : s_fifo

	initial begin
		ARST_N_IN = 1'b0;
		TX_READY_IN = 1'b0;
		RX_VALID_IN = 1'b0;
		RX_DATA_IN = 8'h00;
		FREQ_EST_IN = 8'h91;
		LINK_QUALITY_IN = 8'h2b;
		SIGNAL_STRENGTH_IN = 8'hd4;
		RADIO_STATE_IN = 5'h0d;
		WAKE_TIMER_IN = 16'h1e87;
		PACKET_STATUS_IN = 8'h35;
		SYNTH_CAL_IN = 8'h6a;
		TX_COUNT_IN = 7'h05;
		TX_UNDERFLOW_IN = 1'b1;
		RX_COUNT_IN = 7'h12;
		RX_OVERFLOW_IN = 1'b1;
		RC_CAL_A_IN = 7'h4b;
		RC_CAL_B_IN = 7'h26;
		POWER_INDEX_IN = 3'h0;
		repeat (6) @(posedge CLK_IN);
		ARST_N_IN <= 1'b1;
		@(posedge CLK_IN);
		check_config('{8'h29, 8'h2e, 8'h3f, 8'h07});
		s_status();
		s_strobes();
		s_config();
		s_thresholds();
		s_fifo();
		wrap_up();
	end
endmodule : test_radio_spi_regmap
